// ---- qtimer_pkg.sv ----
// Shared constants for the four-channel timer bank
package qtimer_pkg;

  localparam int unsigned NUM_TMR = 4;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_SYNC = 6;

  // Register map: byte address = region * 16 + word * 4
  localparam logic [3:0] REGION_GLOBAL = 4'h0;
  localparam logic [3:0] REGION_TMR0 = 4'h1;
  localparam logic [1:0] STATUS_WORD = 2'h0;
  localparam logic [1:0] MODE_WORD = 2'h0;
  localparam logic [1:0] REF_WORD = 2'h1;
  localparam logic [1:0] CNT_WORD = 2'h2;
  localparam logic [1:0] CAP_WORD = 2'h3;

  // Mode register fields
  localparam int unsigned MODE_W = 8;
  localparam int unsigned MODE_EN_BIT = 0;
  localparam int unsigned MODE_SRC_LSB = 1;
  localparam int unsigned MODE_EDGE_LSB = 3;
  localparam int unsigned MODE_TOGGLE_BIT = 5;
  localparam int unsigned MODE_GATE_BIT = 6;
  localparam int unsigned MODE_RESTART_BIT = 7;

  // Status register fields
  localparam int unsigned STATUS_W = 8;
  localparam int unsigned STATUS_MATCH_LSB = 0;
  localparam int unsigned STATUS_CAP_LSB = 4;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] REF_RST = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // Count source encodings
  localparam logic [1:0] SRC_CHAIN = 2'h0;
  localparam logic [1:0] SRC_SYS = 2'h1;
  localparam logic [1:0] SRC_DIV16 = 2'h2;
  localparam logic [1:0] SRC_PIN = 2'h3;

  // System clock prescaler, divide by 16
  localparam int unsigned PRESCALE_W = 4;
  localparam logic [3:0] PRESCALE_LAST = 4'hF;

endpackage : qtimer_pkg

// ---- chan_if.sv ----
// Control and result bundle between the timer bank and one counter channel
`timescale 1ns/1ps
interface chan_if #(parameter int unsigned W = 16) ();
  logic en;
  logic tick;
  logic clear;
  logic toggle;
  logic [W-1:0] ref_val;
  logic [W-1:0] cnt;
  logic match;
  logic out_n;

  modport ctl (output en, output tick, output clear, output toggle, output ref_val,
    input cnt, input match, input out_n);
  modport chan (input en, input tick, input clear, input toggle, input ref_val,
    output cnt, output match, output out_n);
endinterface : chan_if

// ---- sync_edge.sv ----
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module sync_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;

  always_comb
  begin
    meta_next = din;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule : sync_edge

// ---- timer_chan.sv ----
// One 16-bit reference counter with its output pin logic
`timescale 1ns/1ps
module timer_chan (
  input wire logic clk,
  input wire logic rst_n,
  chan_if.chan bus
);
  import qtimer_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic out_n_reg;
  logic out_n_next;
  logic hit;

  always_comb
  begin
    hit = bus.en & bus.tick & (cnt_reg == bus.ref_val);
    cnt_next = cnt_reg;
    if (bus.clear)
    begin
      cnt_next = CNT_RST;
    end
    else if (bus.en & bus.tick)
    begin
      cnt_next = hit ? CNT_RST : cnt_reg + 16'h0001;
    end
    if (bus.toggle)
    begin
      out_n_next = out_n_reg ^ hit;
    end
    else
    begin
      out_n_next = ~hit;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= CNT_RST;
      out_n_reg <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_next;
      out_n_reg <= out_n_next;
    end
  end

  assign bus.cnt = cnt_reg;
  assign bus.match = hit;
  assign bus.out_n = out_n_reg;
endmodule : timer_chan

// ---- quad_cascadable_timer.sv ----
// Four cascadable 16-bit timers with capture, gating and an Avalon-MM register port
`timescale 1ns/1ps
module quad_cascadable_timer (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [qtimer_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [qtimer_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [qtimer_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [qtimer_pkg::NUM_TMR-1:0] EXT_COUNT_IN,
  input wire logic GATE_A_IN,
  input wire logic GATE_B_IN,
  output logic [qtimer_pkg::NUM_TMR-1:0] MATCH_OUT_N
);
  import qtimer_pkg::*;

  // Bus handshake
  logic ack_reg;
  logic ack_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] rd_mux;
  logic bus_req;
  logic wr_fire;
  logic [3:0] region;
  logic [1:0] word;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wbits;

  // Synchronised pins: 0..3 count inputs, 4 gate A, 5 gate B
  logic [NUM_SYNC-1:0] pin_raw;
  logic [NUM_SYNC-1:0] pin_level;
  logic [NUM_SYNC-1:0] pin_rise;
  logic [NUM_SYNC-1:0] pin_fall;

  // Prescaler
  logic [PRESCALE_W-1:0] pre_reg;
  logic [PRESCALE_W-1:0] pre_next;
  logic div_tick;

  // Status
  logic [STATUS_W-1:0] status_reg;
  logic [STATUS_W-1:0] status_next;
  logic [NUM_TMR-1:0] match_evt;
  logic [NUM_TMR-1:0] cap_evt;
  logic status_wr;

  // Per timer state, visible to the read mux
  logic [MODE_W-1:0] mode_q [NUM_TMR];
  logic [CNT_W-1:0] ref_q [NUM_TMR];
  logic [CNT_W-1:0] cnt_q [NUM_TMR];
  logic [CNT_W-1:0] cap_q [NUM_TMR];
  logic [NUM_TMR-1:0] match_dly;

  assign bus_req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = bus_req & ~ack_reg;
  assign wr_fire = AVS_WRITE & ack_reg;
  assign region = AVS_ADDRESS[7:4];
  assign word = AVS_ADDRESS[3:2];
  assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wbits = AVS_WRITEDATA & wmask;
  assign AVS_READDATA = rdata_reg;

  // Read path: data latched on the waiting cycle, released one edge later
  always_comb
  begin
    rd_mux = '0;
    if (region == REGION_GLOBAL && word == STATUS_WORD)
    begin
      rd_mux = {{(DATA_W - STATUS_W){1'b0}}, status_reg};
    end
    for (int i = 0; i < NUM_TMR; i++)
    begin
      if (region == 4'(REGION_TMR0 + 4'(i)))
      begin
        case (word)
          MODE_WORD: rd_mux = {{(DATA_W - MODE_W){1'b0}}, mode_q[i]};
          REF_WORD: rd_mux = {{(DATA_W - CNT_W){1'b0}}, ref_q[i]};
          CNT_WORD: rd_mux = {{(DATA_W - CNT_W){1'b0}}, cnt_q[i]};
          CAP_WORD: rd_mux = {{(DATA_W - CNT_W){1'b0}}, cap_q[i]};
          default: rd_mux = '0;
        endcase
      end
    end
    ack_next = bus_req & ~ack_reg;
    rdata_next = (AVS_READ & ~ack_reg) ? rd_mux : rdata_reg;
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Pin synchronisers
  assign pin_raw = {GATE_B_IN, GATE_A_IN, EXT_COUNT_IN};

  genvar s;
  generate
    for (s = 0; s < NUM_SYNC; s++)
    begin : g_sync
      sync_edge u_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .din(pin_raw[s]),
        .level(pin_level[s]),
        .rise(pin_rise[s]),
        .fall(pin_fall[s])
      );
    end
  endgenerate

  // Divide-by-16 tick from the system clock
  always_comb
  begin
    pre_next = pre_reg + 4'h1;
    div_tick = (pre_reg == PRESCALE_LAST);
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pre_reg <= '0;
    end
    else
    begin
      pre_reg <= pre_next;
    end
  end

  // Sticky event flags, write one to clear; a new event wins over the clear
  assign status_wr = wr_fire & (region == REGION_GLOBAL) & (word == STATUS_WORD);

  always_comb
  begin
    status_next = status_reg;
    if (status_wr)
    begin
      status_next = status_reg & ~wbits[STATUS_W-1:0];
    end
    status_next[STATUS_MATCH_LSB +: NUM_TMR] =
      status_next[STATUS_MATCH_LSB +: NUM_TMR] | match_evt;
    status_next[STATUS_CAP_LSB +: NUM_TMR] =
      status_next[STATUS_CAP_LSB +: NUM_TMR] | cap_evt;
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      status_reg <= STATUS_RST;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // Timer channels
  genvar k;
  generate
    for (k = 0; k < NUM_TMR; k++)
    begin : g_tmr
      localparam logic [3:0] MY_REGION = 4'(REGION_TMR0 + 4'(k));
      localparam int unsigned GATE_IDX = NUM_TMR + (k / 2);
      localparam int unsigned CHAIN_IDX = (k + NUM_TMR - 1) % NUM_TMR;

      chan_if #(.W(CNT_W)) cif ();

      logic [MODE_W-1:0] mode_reg;
      logic [MODE_W-1:0] mode_next;
      logic [CNT_W-1:0] ref_reg;
      logic [CNT_W-1:0] ref_next;
      logic [CNT_W-1:0] cap_reg;
      logic [CNT_W-1:0] cap_next;
      logic dly_reg;
      logic dly_next;
      logic sel;
      logic edge_hit;
      logic src_tick;
      logic gate_open;
      logic gate_restart;
      logic sw_clear;
      logic [1:0] src;
      logic [1:0] edge_sel;

      assign sel = wr_fire & (region == MY_REGION);
      assign src = mode_reg[MODE_SRC_LSB +: 2];
      assign edge_sel = mode_reg[MODE_EDGE_LSB +: 2];

      always_comb
      begin
        // Selected pin edges for capture and pin counting
        edge_hit = (edge_sel[0] & pin_rise[k]) | (edge_sel[1] & pin_fall[k]);
        case (src)
          SRC_CHAIN: src_tick = match_dly[CHAIN_IDX];
          SRC_SYS: src_tick = 1'b1;
          SRC_DIV16: src_tick = div_tick;
          SRC_PIN: src_tick = edge_hit;
          default: src_tick = 1'b0;
        endcase
        // Gate held high stops the count; a falling gate edge restarts it
        gate_open = ~(mode_reg[MODE_GATE_BIT] & pin_level[GATE_IDX]);
        gate_restart = mode_reg[MODE_RESTART_BIT] & pin_fall[GATE_IDX];
        sw_clear = sel & (word == CNT_WORD);
        mode_next = mode_reg;
        ref_next = ref_reg;
        if (sel && word == MODE_WORD)
        begin
          mode_next = (mode_reg & ~wmask[MODE_W-1:0]) | wbits[MODE_W-1:0];
        end
        if (sel && word == REF_WORD)
        begin
          ref_next = (ref_reg & ~wmask[CNT_W-1:0]) | wbits[CNT_W-1:0];
        end
        cap_next = (mode_reg[MODE_EN_BIT] & edge_hit) ? cif.cnt : cap_reg;
        dly_next = cif.match;
      end

      always_ff @(posedge MCLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          mode_reg <= MODE_RST;
          ref_reg <= REF_RST;
          cap_reg <= CNT_RST;
          dly_reg <= 1'b0;
        end
        else
        begin
          mode_reg <= mode_next;
          ref_reg <= ref_next;
          cap_reg <= cap_next;
          dly_reg <= dly_next;
        end
      end

      assign cif.en = mode_reg[MODE_EN_BIT];
      assign cif.tick = src_tick & gate_open;
      assign cif.clear = sw_clear | gate_restart;
      assign cif.toggle = mode_reg[MODE_TOGGLE_BIT];
      assign cif.ref_val = ref_reg;

      timer_chan u_chan (
        .clk(MCLK),
        .rst_n(RST_N),
        .bus(cif)
      );

      assign MATCH_OUT_N[k] = cif.out_n;
      assign match_evt[k] = cif.match;
      assign cap_evt[k] = mode_reg[MODE_EN_BIT] & edge_hit;
      assign match_dly[k] = dly_reg;
      assign mode_q[k] = mode_reg;
      assign ref_q[k] = ref_reg;
      assign cnt_q[k] = cif.cnt;
      assign cap_q[k] = cap_reg;
    end
  endgenerate

endmodule : quad_cascadable_timer

// ---- qtimer_asserts.sv ----
// Port checks for the timer bank
`timescale 1ns/1ps
module qtimer_asserts (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [qtimer_pkg::DATA_W-1:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [qtimer_pkg::NUM_TMR-1:0] MATCH_OUT_N
);
  import qtimer_pkg::*;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  wire logic req = AVS_READ || AVS_WRITE;
  sequence s_wait;
    req && AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    req && !AVS_WAITREQUEST;
  endsequence
  property p_idle;
    !req |-> !AVS_WAITREQUEST;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest with no request");
  property p_first;
    $rose(req) |-> AVS_WAITREQUEST;
  endproperty
  a_first: assert property (p_first) else $error("no wait cycle on new request");
  property p_one;
    s_wait |=> s_ack;
  endproperty
  a_one: assert property (p_one) else $error("more than one wait cycle");
  property p_again;
    s_ack ##1 req |-> AVS_WAITREQUEST;
  endproperty
  a_again: assert property (p_again) else $error("back to back request skipped wait");
  property p_hold;
    !AVS_READ |=> $stable(AVS_READDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_narrow;
    AVS_READDATA[31:16] == 16'h0000;
  endproperty
  a_narrow: assert property (p_narrow) else $error("read data above bit 15");
  property p_rst_out;
    $rose(RST_N) |-> (MATCH_OUT_N == 4'hF) [*4];
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_rst_rd;
    $rose(RST_N) |-> AVS_READDATA == 32'h0000_0000;
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("read data not clear after reset");
endmodule : qtimer_asserts
bind quad_cascadable_timer qtimer_asserts i_qtimer_asserts (
  .MCLK(MCLK),
  .RST_N(RST_N),
  .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .MATCH_OUT_N(MATCH_OUT_N)
);

// ---- board_model.sv ----
// Board-side driver of count pins and gates
`timescale 1ns/1ps
module board_model (
  input wire logic clk,
  output logic [3:0] pins,
  output logic gate_a,
  output logic gate_b
);
  initial
  begin
    pins = 4'h0;
    gate_a = 1'b0;
    gate_b = 1'b0;
  end
  // Pulses held four cycles high and five low
  task pulses(input logic [3:0] m, input int n);
    repeat (n)
    begin
      @(posedge clk);
      pins <= m;
      repeat (4) @(posedge clk);
      pins <= 4'h0;
      repeat (4) @(posedge clk);
    end
  endtask : pulses
  task gates(input logic a, input logic b);
    @(posedge clk);
    gate_a <= a;
    gate_b <= b;
  endtask : gates
endmodule : board_model

// ---- quad_cascadable_timer_test.sv ----
// Self-checking bench for the four-channel timer bank
`timescale 1ns/1ps
module quad_cascadable_timer_test;
  import qtimer_pkg::*;
  typedef struct {int t; logic [7:0] m; logic [15:0] r; int p; int w;} row_s;
  typedef struct {logic [7:0] a; logic [31:0] e;} reg_s;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [ADDR_W-1:0] AVS_ADDRESS = '0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [DATA_W-1:0] AVS_WRITEDATA = '0;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [DATA_W-1:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [NUM_TMR-1:0] EXT_COUNT_IN;
  logic GATE_A_IN;
  logic GATE_B_IN;
  logic [NUM_TMR-1:0] MATCH_OUT_N;
  int bad_count = 0;
  int compares = 0;
  // Keep asks xfer to leave the strobe up for a back-to-back request
  logic keep = 1'b0;
  logic held = 1'b0;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic [7:0] b;
  int p;
  int w;
  row_s rows [4] = '{'{0, 8'h03, 16'h0002, 3, 1}, '{1, 8'h23, 16'h0003, 8, 4},
    '{2, 8'h05, 16'h0001, 32, 1}, '{3, 8'h25, 16'h0000, 32, 16}};
  reg_s regs [7] = '{'{8'h00, 32'h0}, '{8'h10, 32'h0}, '{8'h14, 32'h0000_FFFF},
    '{8'h18, 32'h0}, '{8'h1C, 32'h0}, '{8'h44, 32'h0000_FFFF}, '{8'h50, 32'h0}};
  always #4 MCLK = ~MCLK;
  quad_cascadable_timer i_quad_cascadable_timer (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .EXT_COUNT_IN(EXT_COUNT_IN),
    .GATE_A_IN(GATE_A_IN),
    .GATE_B_IN(GATE_B_IN),
    .MATCH_OUT_N(MATCH_OUT_N)
  );
  board_model i_board_model (
    .clk(MCLK),
    .pins(EXT_COUNT_IN),
    .gate_a(GATE_A_IN),
    .gate_b(GATE_B_IN)
  );
  task summarize;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low at a rising edge
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    if (!held) @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge MCLK);
    rd = AVS_READDATA;
    held = keep;
    if (!keep)
    begin
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
    end
  endtask : xfer
  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  // Cycles between two falls of one output, and low cycles in between
  task per(input int i, output int pp, output int ww);
    int f;
    logic q;
    f = 0;
    pp = 0;
    ww = 0;
    q = MATCH_OUT_N[i];
    while (f < 2)
    begin
      @(negedge MCLK);
      if (q === 1'b1 && MATCH_OUT_N[i] === 1'b0) f++;
      if (f == 1) pp++;
      if (f == 1 && MATCH_OUT_N[i] === 1'b0) ww++;
      q = MATCH_OUT_N[i];
    end
  endtask : per
  initial
  begin
    repeat (30000) @(posedge MCLK);
    bad_count++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge MCLK);
    RST_N <= 1'b1;
    @(negedge MCLK);
    chk(32'(MATCH_OUT_N), 32'h0000_000F);
    xfer(1'b1, 8'h50, 32'hFFFF_FFFF);
    foreach (regs[k]) rdc(regs[k].a, regs[k].e);
    $display("done: register defaults");
    foreach (rows[k])
    begin
      b = 8'(16 * rows[k].t + 16);
      xfer(1'b1, b + 8'h04, 32'(rows[k].r));
      xfer(1'b1, b, 32'(rows[k].m));
      per(rows[k].t, p, w);
      chk(p, rows[k].p);
      chk(w, rows[k].w);
      xfer(1'b1, b, 32'h0);
      $display("done: row %0d", k);
    end
    @(posedge MCLK);
    RST_N <= 1'b0;
    @(negedge MCLK);
    chk(32'(MATCH_OUT_N), 32'h0000_000F);
    @(posedge MCLK);
    RST_N <= 1'b1;
    rdc(8'h24, 32'h0000_FFFF);
    $display("done: mid-run reset");
    xfer(1'b1, 8'h14, 32'h1);
    xfer(1'b1, 8'h10, 32'h3);
    xfer(1'b1, 8'h24, 32'h1);
    xfer(1'b1, 8'h20, 32'h1);
    per(1, p, w);
    chk(p, 4);
    $display("done: chained pair");
    xfer(1'b1, 8'h30, 32'h1F);
    xfer(1'b1, 8'h40, 32'h17);
    i_board_model.pulses(4'hC, 3);
    repeat (8) @(posedge MCLK);
    rdc(8'h38, 32'h6);
    rdc(8'h48, 32'h3);
    rdc(8'h3C, 32'h5);
    rdc(8'h4C, 32'h2);
    xfer(1'b0, 8'h00, 32'h0);
    chk(32'(rd[7:6]), 32'h3);
    $display("done: pin counting");
    xfer(1'b1, 8'h14, 32'hFFFF);
    xfer(1'b1, 8'h10, 32'h43);
    i_board_model.gates(1'b1, 1'b1);
    repeat (8) @(posedge MCLK);
    xfer(1'b0, 8'h18, 32'h0);
    rd2 = rd;
    rdc(8'h18, rd2);
    i_board_model.gates(1'b0, 1'b1);
    repeat (8) @(posedge MCLK);
    xfer(1'b0, 8'h18, 32'h0);
    rd2 = rd + 32'h3;
    rdc(8'h18, rd2);
    xfer(1'b1, 8'h30, 32'h83);
    repeat (100) @(posedge MCLK);
    i_board_model.gates(1'b0, 1'b0);
    repeat (8) @(posedge MCLK);
    xfer(1'b0, 8'h38, 32'h0);
    chk(32'(rd < 32'h10), 32'h1);
    $display("done: gates");
    AVS_BYTEENABLE <= 4'h1;
    xfer(1'b1, 8'h44, 32'h0000_1234);
    AVS_BYTEENABLE <= 4'hF;
    keep = 1'b1;
    rdc(8'h44, 32'h0000_FF34);
    keep = 1'b0;
    rdc(8'h14, 32'h0000_FFFF);
    $display("done: byte lanes and back-to-back reads");
    summarize();
  end
endmodule : quad_cascadable_timer_test
